// >>> lpdpi_core.v
`timescale 1ns/10ps
`include "lpdpi_map.vh"
module lpdpi_core (
   // System clock and reset
   input  wire                     clk_in,
   input  wire                     rst_in,
   // Link clock pair and clock gate
   input  wire                     ck_in,
   input  wire                     ck_n_in,
   input  wire                     cke_in,
   // Command and address
   input  wire                     cs_n_in,
   input  wire                     ras_n_in,
   input  wire                     cas_n_in,
   input  wire                     we_n_in,
   input  wire [1:0]               array_group_sel_in,
   input  wire [`LPDPI_ADDR_W-1:0] addr_in,
   // Data bus
   input  wire [`LPDPI_DQ_W-1:0]   dq_in,
   output reg  [`LPDPI_DQ_W-1:0]   dq_out,
   output reg                      dq_oe_out,
   // Data strobes
   input  wire                     lower_data_strobe_in,
   input  wire                     upper_data_strobe_in,
   output reg                      lower_data_strobe_out,
   output reg                      upper_data_strobe_out,
   output reg                      lower_data_strobe_oe_out,
   output reg                      upper_data_strobe_oe_out,
   // Byte masks, input only
   input  wire                     lower_byte_mask_in,   // [RULE_10]
   input  wire                     upper_byte_mask_in,   // [RULE_10]
   // Status
   output reg  [`LPDPI_ADDR_W-1:0] mode_reg_out,
   output reg  [3:0]               bank_open_out,
   output reg                      active_out
);

   localparam ST_IDLE  = 3'b001;
   localparam ST_READ  = 3'b010;
   localparam ST_WRITE = 3'b100;

   wire [`LPDPI_SYNC_W-1:0] pin_s;
   wire                     ck_s;
   wire                     ck_n_s;
   wire                     cke_s;
   wire                     cs_n_s;
   wire                     ras_n_s;
   wire                     cas_n_s;
   wire                     we_n_s;
   wire [1:0]               bank_s;
   wire [`LPDPI_ADDR_W-1:0] addr_s;
   wire [`LPDPI_DQ_W-1:0]   dq_s;
   wire [1:0]               dqs_s;
   wire [1:0]               mask_s;
   wire [2:0]               cmd;
   wire                     ck_rise;
   wire                     ck_fall;
   wire                     cmd_take;
   wire [1:0]               dqs_edge;

   reg  [2:0]               state_q;
   reg                      ck_prev_q;
   reg  [`LPDPI_ADDR_W-1:0] row_q [0:3];
   reg  [1:0]               bank_q;
   reg  [`LPDPI_COL_W-1:0]  base_q;
   reg  [`LPDPI_COL_W-1:0]  mask_bits_q;
   reg  [3:0]               bl_q;
   reg  [3:0]               rd_beat_q;
   reg                      rd_run_q;
   reg                      close_q;
   reg  [3:0]               lane_beat_q [0:1];
   reg  [`LPDPI_DQ_W-1:0]   mem_q [0:`LPDPI_DEPTH-1];
   reg  [1:0]               wr_en;
   reg  [`LPDPI_IDX_W-1:0]  wr_idx [0:1];
   reg  [3:0]               bl_new;
   reg  [`LPDPI_COL_W-1:0]  mask_new;
   integer                  i;
   integer                  j;
   integer                  k;

   // Column inside the burst, wrapping sequentially at its boundary
   function [`LPDPI_COL_W-1:0] burst_col;
      input [`LPDPI_COL_W-1:0] base;
      input [3:0]              beat;
      input [`LPDPI_COL_W-1:0] wrap;
      reg   [`LPDPI_COL_W-1:0] sum;
      begin
         sum       = base + beat[`LPDPI_COL_W-1:0];
         burst_col = (base & ~wrap) | (sum & wrap);
      end
   endfunction

   // Every pin crosses two flops; equal delay keeps them aligned to each other
   lpdpi_sync #(
      .W (`LPDPI_SYNC_W)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .async_in ({ck_in, ck_n_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
                  array_group_sel_in, addr_in, dq_in,
                  upper_data_strobe_in, lower_data_strobe_in,
                  upper_byte_mask_in, lower_byte_mask_in}),
      .sync_out (pin_s)
   );

   assign {ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s,
           bank_s, addr_s, dq_s, dqs_s, mask_s} = pin_s;

   lpdpi_cmd_dec u_dec (
      .cs_n_in  (cs_n_s),
      .ras_n_in (ras_n_s),
      .cas_n_in (cas_n_s),
      .we_n_in  (we_n_s),
      .cmd_out  (cmd)
   );

   assign ck_rise  = ck_s & ~ck_prev_q & ~ck_n_s;            // [RULE_11]
   assign ck_fall  = ~ck_s & ck_prev_q;
   assign cmd_take = ck_rise & cke_s;                        // [RULE_11] [RULE_15]

   // Both strobe directions mark a write beat
   genvar g;
   generate
      for (g = 0; g < `LPDPI_LANES; g = g + 1)
      begin : gen_lane
         reg dqs_prev_q;
         always @(posedge clk_in)
         begin
            if (rst_in)
               dqs_prev_q <= 1'b0;
            else
               dqs_prev_q <= dqs_s[g];
         end
         assign dqs_edge[g] = (dqs_s[g] ^ dqs_prev_q) & (state_q == ST_WRITE) & cke_s;  // [RULE_08] [RULE_16]
      end
   endgenerate

   // Burst length code: 1, 2, 3 give 2, 4, 8 beats; 16 is not stored
   always @*
   begin
      case (mode_reg_out[`LPDPI_BL_MSB:`LPDPI_BL_LSB])
         3'h2:
         begin
            bl_new   = 4'h4;
            mask_new = 3'h3;
         end
         3'h3:
         begin
            bl_new   = 4'h8;
            mask_new = 3'h7;
         end
         default:
         begin
            bl_new   = 4'h2;
            mask_new = 3'h1;
         end
      endcase
   end

   // Write strobes per lane; masked bytes never reach storage
   always @*
   begin
      for (i = 0; i < `LPDPI_LANES; i = i + 1)
      begin
         wr_en[i]  = dqs_edge[i] & (lane_beat_q[i] < bl_q) & ~mask_s[i];  // [RULE_07] [RULE_09]
         wr_idx[i] = {bank_q, burst_col(base_q, lane_beat_q[i], mask_bits_q)};  // [RULE_03] [RULE_04]
      end
   end

   always @(posedge clk_in)
   begin
      for (j = 0; j < `LPDPI_LANES; j = j + 1)
      begin
         if (wr_en[j])
            mem_q[wr_idx[j]][j*8 +: 8] <= dq_s[j*8 +: 8];  // [RULE_12] [RULE_13]
      end
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_q                  <= ST_IDLE;
         ck_prev_q                <= 1'b0;
         bank_q                   <= 2'h0;
         base_q                   <= 3'h0;
         mask_bits_q              <= 3'h1;
         bl_q                     <= 4'h2;
         rd_beat_q                <= 4'h0;
         rd_run_q                 <= 1'b0;
         close_q                  <= 1'b0;
         lane_beat_q[0]           <= 4'h0;
         lane_beat_q[1]           <= 4'h0;
         for (k = 0; k < 4; k = k + 1)
            row_q[k] <= {`LPDPI_ADDR_W{1'b0}};
         dq_out                   <= {`LPDPI_DQ_W{1'b0}};
         dq_oe_out                <= 1'b0;
         lower_data_strobe_out    <= 1'b0;
         upper_data_strobe_out    <= 1'b0;
         lower_data_strobe_oe_out <= 1'b0;
         upper_data_strobe_oe_out <= 1'b0;
         mode_reg_out             <= `LPDPI_MODE_RST;
         bank_open_out            <= 4'h0;
         active_out               <= 1'b0;
      end
      else
      begin
         ck_prev_q  <= ck_s;
         active_out <= cke_s;
         if (!cke_s)
         begin
            // Clock gate low: drivers off, any burst abandoned
            state_q                  <= ST_IDLE;   // [RULE_15]
            rd_run_q                 <= 1'b0;
            dq_oe_out                <= 1'b0;
            lower_data_strobe_oe_out <= 1'b0;
            upper_data_strobe_oe_out <= 1'b0;
         end
         else if (cmd_take && cmd != `LPDPI_CMD_NOP && cmd != `LPDPI_CMD_REF)
         begin
            case (cmd)
               `LPDPI_CMD_ACT:
               begin
                  row_q[bank_s]         <= addr_s;          // [RULE_03] [RULE_04]
                  bank_open_out[bank_s] <= 1'b1;
               end
               `LPDPI_CMD_RD,
               `LPDPI_CMD_WR:
               begin
                  // A burst to a closed bank is dropped
                  if (bank_open_out[bank_s])
                  begin
                     bank_q         <= bank_s;               // [RULE_03]
                     base_q         <= addr_s[`LPDPI_COL_W-1:0];  // [RULE_04]
                     close_q        <= addr_s[`LPDPI_AUTOCLOSE_BIT];  // [RULE_05]
                     bl_q           <= bl_new;
                     mask_bits_q    <= mask_new;
                     rd_beat_q      <= 4'h0;
                     rd_run_q       <= 1'b0;
                     lane_beat_q[0] <= 4'h0;
                     lane_beat_q[1] <= 4'h0;
                     state_q        <= (cmd == `LPDPI_CMD_RD) ? ST_READ : ST_WRITE;
                  end
                  dq_oe_out                <= 1'b0;
                  lower_data_strobe_oe_out <= 1'b0;
                  upper_data_strobe_oe_out <= 1'b0;
               end
               `LPDPI_CMD_PRE:
               begin
                  if (addr_s[`LPDPI_AUTOCLOSE_BIT])
                     bank_open_out <= 4'h0;
                  else
                     bank_open_out[bank_s] <= 1'b0;        // [RULE_03]
               end
               `LPDPI_CMD_BST:
               begin
                  state_q                  <= ST_IDLE;
                  rd_run_q                 <= 1'b0;
                  dq_oe_out                <= 1'b0;
                  lower_data_strobe_oe_out <= 1'b0;
                  upper_data_strobe_oe_out <= 1'b0;
               end
               `LPDPI_CMD_MRS:
                  mode_reg_out <= addr_s;                  // [RULE_06]
               default:
                  state_q <= state_q;
            endcase
         end
         else
         begin
            case (state_q)
               ST_READ:
               begin
                  // First beat one link period after the command
                  if ((ck_rise && !rd_run_q) || ((ck_rise || ck_fall) && rd_run_q))
                  begin
                     if (rd_beat_q == bl_q)
                     begin
                        state_q                  <= ST_IDLE;
                        rd_run_q                 <= 1'b0;
                        dq_oe_out                <= 1'b0;   // [RULE_13]
                        lower_data_strobe_oe_out <= 1'b0;
                        upper_data_strobe_oe_out <= 1'b0;
                        if (close_q)
                           bank_open_out[bank_q] <= 1'b0;   // [RULE_05]
                     end
                     else
                     begin
                        rd_run_q                 <= 1'b1;
                        dq_out                   <= mem_q[{bank_q, burst_col(base_q, rd_beat_q, mask_bits_q)}];
                        dq_oe_out                <= 1'b1;   // [RULE_12] [RULE_13]
                        lower_data_strobe_out    <= ck_s;   // [RULE_16]
                        upper_data_strobe_out    <= ck_s;
                        lower_data_strobe_oe_out <= 1'b1;
                        upper_data_strobe_oe_out <= 1'b1;
                        rd_beat_q                <= rd_beat_q + 4'h1;
                     end
                  end
               end
               ST_WRITE:
               begin
                  // Masked beats still count, so the lanes stay in step
                  for (k = 0; k < `LPDPI_LANES; k = k + 1)
                  begin
                     if (dqs_edge[k] && lane_beat_q[k] < bl_q)
                        lane_beat_q[k] <= lane_beat_q[k] + 4'h1;  // [RULE_08]
                  end
                  if (lane_beat_q[0] == bl_q && lane_beat_q[1] == bl_q)
                  begin
                     state_q <= ST_IDLE;
                     if (close_q)
                        bank_open_out[bank_q] <= 1'b0;      // [RULE_05]
                  end
               end
               default:
                  state_q <= ST_IDLE;
            endcase
         end
      end
   end

endmodule

// >>> lpdpi_map.vh
// Contract
// (RULE_01) The command decoder acts only when chip select is sampled low; with it high every command is ignored.
// (RULE_02) The command is formed from row, column and write strobes plus chip select, all sampled on one clock edge.
// (RULE_03) Activate, read, write and single-bank precharge act only on the bank given by array_group_sel.
// (RULE_04) Address carries the row with activate and the column with read or write, selecting one location; code indexes by bank and column, not the row.
// (RULE_05) With read or write, address bit 10 is autoclose_flag and closes the row after the burst.
// (RULE_06) During a mode-register program the address value is loaded as the opcode, not used as an address.
// (RULE_07) During a write a byte whose byte_mask is sampled high with it is not stored; low stores it.
// (RULE_08) The byte masks are sampled on both rising and falling data strobe edges, one mask per write beat.
// (RULE_09) Each byte mask governs one eight-bit lane: lower_byte_mask the low byte, upper_byte_mask the high byte.
// (RULE_10) The byte-mask pins are inputs only and are never driven, not even during reads.
// (RULE_11) Address and control inputs are sampled only where the true clock rises and the complement falls.
// (RULE_12) Read and write data move on both directions of the clock crossing, two transfers per period.
// (RULE_13) The data bus is driven by the device during reads only and received during writes.
// (RULE_14) A controller with several devices may use one chip select per device to steer each command.
// (RULE_15) With the clock-gate input high the device works; low deactivates its clocks, inputs and drivers.
// (RULE_16) The device drives each lane's data strobe with read data and captures write data on the strobe.
// (RULE_17) Commands decode as no-operation, activate, read, write, precharge, refresh, burst stop and mode program.
`ifndef LPDPI_MAP_VH
`define LPDPI_MAP_VH

`define LPDPI_ADDR_W        13
`define LPDPI_DQ_W          16
`define LPDPI_LANES         2
`define LPDPI_COL_W         3
`define LPDPI_IDX_W         5
`define LPDPI_DEPTH         32
`define LPDPI_AUTOCLOSE_BIT 10
`define LPDPI_BL_MSB        2
`define LPDPI_BL_LSB        0
`define LPDPI_MODE_RST      13'h0000
`define LPDPI_SYNC_W        42

// Pin levels of {row, column, write} strobes
`define LPDPI_PIN_MRS       3'h0
`define LPDPI_PIN_REF       3'h1
`define LPDPI_PIN_PRE       3'h2
`define LPDPI_PIN_ACT       3'h3
`define LPDPI_PIN_WR        3'h4
`define LPDPI_PIN_RD        3'h5
`define LPDPI_PIN_BST       3'h6

// Decoded command codes
`define LPDPI_CMD_NOP       3'h0
`define LPDPI_CMD_ACT       3'h1
`define LPDPI_CMD_RD        3'h2
`define LPDPI_CMD_WR        3'h3
`define LPDPI_CMD_PRE       3'h4
`define LPDPI_CMD_REF       3'h5
`define LPDPI_CMD_BST       3'h6
`define LPDPI_CMD_MRS       3'h7

`endif

// >>> lpdpi_sync.v
`timescale 1ns/10ps
module lpdpi_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk_in,
   input  wire         rst_in,
   // Pins in, synchronised out
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] stable_q;

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         meta_q   <= {W{1'b0}};
         stable_q <= {W{1'b0}};
      end
      else
      begin
         meta_q   <= async_in;
         stable_q <= meta_q;
      end
   end

   assign sync_out = stable_q;

endmodule

// >>> lpdpi_cmd_dec.v
`timescale 1ns/10ps
`include "lpdpi_map.vh"
module lpdpi_cmd_dec (
   // Sampled command pins
   input  wire       cs_n_in,
   input  wire       ras_n_in,
   input  wire       cas_n_in,
   input  wire       we_n_in,
   // Decoded command
   output reg  [2:0] cmd_out
);

   always @*
   begin
      cmd_out = `LPDPI_CMD_NOP;
      if (!cs_n_in)                                     // [RULE_01]
      begin
         case ({ras_n_in, cas_n_in, we_n_in})           // [RULE_02] [RULE_17]
            `LPDPI_PIN_MRS: cmd_out = `LPDPI_CMD_MRS;
            `LPDPI_PIN_REF: cmd_out = `LPDPI_CMD_REF;
            `LPDPI_PIN_PRE: cmd_out = `LPDPI_CMD_PRE;
            `LPDPI_PIN_ACT: cmd_out = `LPDPI_CMD_ACT;
            `LPDPI_PIN_WR:  cmd_out = `LPDPI_CMD_WR;
            `LPDPI_PIN_RD:  cmd_out = `LPDPI_CMD_RD;
            `LPDPI_PIN_BST: cmd_out = `LPDPI_CMD_BST;
            default:        cmd_out = `LPDPI_CMD_NOP;
         endcase
      end
   end

endmodule

// >>> lpdpi_core_props.sv
`timescale 1ns/10ps
`include "lpdpi_map.vh"
module lpdpi_core_props (
   // Clock and reset
   input wire logic                     clk_in,
   input wire logic                     rst_in,
   // Command pins
   input wire logic                     ck_in,
   input wire logic                     ck_n_in,
   input wire logic                     cke_in,
   input wire logic                     cs_n_in,
   input wire logic                     ras_n_in,
   input wire logic                     cas_n_in,
   input wire logic                     we_n_in,
   input wire logic [1:0]               array_group_sel_in,
   input wire logic [`LPDPI_ADDR_W-1:0] addr_in,
   // Device outputs
   input wire logic [`LPDPI_DQ_W-1:0]   dq_out,
   input wire logic                     dq_oe_out,
   input wire logic                     lower_data_strobe_out,
   input wire logic                     upper_data_strobe_out,
   input wire logic                     lower_data_strobe_oe_out,
   input wire logic                     upper_data_strobe_oe_out,
   input wire logic [`LPDPI_ADDR_W-1:0] mode_reg_out,
   input wire logic [3:0]               bank_open_out,
   input wire logic                     active_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_mrs;
      $rose(ck_in) && !ck_n_in && cke_in && !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;
   endsequence
   sequence s_open;
      (bank_open_out & ~$past(bank_open_out)) != 4'h0;
   endsequence
   sequence s_beat;
      dq_oe_out && $past(dq_oe_out) && $changed(dq_out);
   endsequence
   oe_pair_a: assert property (
      lower_data_strobe_oe_out == dq_oe_out && upper_data_strobe_oe_out == dq_oe_out)
      else $error("enable mismatch");
   stb_pair_a: assert property (dq_oe_out |-> lower_data_strobe_out == upper_data_strobe_out)
      else $error("lane strobes differ");
   cke_off_a: assert property (!cke_in [*6] |-> !dq_oe_out && !active_out)
      else $error("active while gated");
   cke_on_a: assert property (cke_in [*6] |-> active_out)
      else $error("inactive while ungated");
   mrs_take_a: assert property (s_mrs |-> ##[2:6] mode_reg_out == addr_in)
      else $error("mode not loaded");
   mode_hold_a: assert property ($changed(mode_reg_out) |-> !cs_n_in && mode_reg_out == addr_in)
      else $error("mode changed unselected");
   bank_open_a: assert property (s_open |-> ck_in && !ck_n_in && !cs_n_in && !ras_n_in && cas_n_in && we_n_in
      && (bank_open_out & ~$past(bank_open_out)) == (4'h1 << array_group_sel_in))
      else $error("bank opened unasked");
   beat_edge_a: assert property (s_beat |-> lower_data_strobe_out == ck_in)
      else $error("beat off clock");
   oe_start_a: assert property ($rose(dq_oe_out) |-> ck_in && lower_data_strobe_out)
      else $error("burst start off rise");
endmodule

// >>> lpdpi_ctl_model.sv
`timescale 1ns/10ps
`include "lpdpi_map.vh"
module lpdpi_ctl_model (
   // Clock
   input  wire                     clk_in,
   // Device drivers
   input  wire [`LPDPI_DQ_W-1:0]   dev_dq_in,
   input  wire                     dev_dq_oe_in,
   input  wire                     dev_lo_stb_in,
   input  wire                     dev_hi_stb_in,
   input  wire                     dev_lo_stb_oe_in,
   input  wire                     dev_hi_stb_oe_in,
   // Command pins
   output reg                      ck_out,
   output reg                      ck_n_out,
   output reg                      cke_out,
   output reg                      cs_n_out,
   output reg  [2:0]               cmd_pins_out,
   output reg  [1:0]               bank_out,
   output reg  [`LPDPI_ADDR_W-1:0] addr_out,
   // Resolved data side
   output wire [`LPDPI_DQ_W-1:0]   dq_out,
   output wire                     lower_data_strobe_out,
   output wire                     upper_data_strobe_out,
   output reg                      lower_byte_mask_out,
   output reg                      upper_byte_mask_out
);
   reg [`LPDPI_DQ_W-1:0] dq_q;
   reg                   dq_oe_q;
   reg                   stb_q;
   // Undriven bus shows the inverse so a stale word never passes
   assign dq_out = dev_dq_oe_in ? dev_dq_in : (dq_oe_q ? dq_q : ~dq_q);
   assign lower_data_strobe_out = dev_lo_stb_oe_in ? dev_lo_stb_in : stb_q;
   assign upper_data_strobe_out = dev_hi_stb_oe_in ? dev_hi_stb_in : stb_q;
   initial
   begin
      ck_out = 1'b0;
      ck_n_out = 1'b1;
      cke_out = 1'b1;
      cs_n_out = 1'b1;
      cmd_pins_out = 3'h7;
      bank_out = 2'h0;
      addr_out = 13'h0000;
      dq_q = 16'h0000;
      dq_oe_q = 1'b0;
      stb_q = 1'b0;
      lower_byte_mask_out = 1'b0;
      upper_byte_mask_out = 1'b0;
   end
   // Pins held well around the rise for the synchronisers
   task cmd(input [2:0] pins, input [1:0] bank, input [`LPDPI_ADDR_W-1:0] addr, input desel, input bad_ckn);
      begin
         @(negedge clk_in);
         cs_n_out = desel;
         cmd_pins_out = pins;
         bank_out = bank;
         addr_out = addr;
         repeat (4) @(negedge clk_in);
         ck_out = 1'b1;
         ck_n_out = bad_ckn;
         repeat (8) @(negedge clk_in);
         ck_out = 1'b0;
         ck_n_out = 1'b1;
         repeat (8) @(negedge clk_in);
         cs_n_out = 1'b1;
         cmd_pins_out = 3'h7;
         bank_out = ~bank_out;
         addr_out = ~addr_out;
      end
   endtask
   task ck_edge(input integer n);
      begin
         ck_out = ~ck_out;
         ck_n_out = ~ck_out;
         repeat (n) @(negedge clk_in);
      end
   endtask
   // Strobe centred in the beat
   task wr_beat(input [`LPDPI_DQ_W-1:0] d, input lm, input um);
      begin
         dq_q = d;
         dq_oe_q = 1'b1;
         lower_byte_mask_out = lm;
         upper_byte_mask_out = um;
         ck_edge(4);
         stb_q = ~stb_q;
         repeat (4) @(negedge clk_in);
      end
   endtask
   task wr_done;
      begin
         dq_oe_q = 1'b0;
         lower_byte_mask_out = 1'b0;
         upper_byte_mask_out = 1'b0;
      end
   endtask
   task set_cke(input v);
      cke_out = v;
   endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
`include "lpdpi_map.vh"
module tb_top;
   reg                     clk_in;
   reg                     rst_in;
   integer                 mismatches;
   integer                 n_tests;
   integer                 cycles;
   wire                    ck, ck_n, cke, cs_n, lo_stb, hi_stb, lo_msk, hi_msk;
   wire [2:0]              pins;
   wire [1:0]              bank;
   wire [`LPDPI_ADDR_W-1:0] addr, mode_reg;
   wire [`LPDPI_DQ_W-1:0]  dq_bus, dq_dev;
   wire                    dq_oe, lo_so, hi_so, lo_soe, hi_soe, active;
   wire [3:0]              bank_open;
   lpdpi_core u_dut (.clk_in(clk_in), .rst_in(rst_in), .ck_in(ck), .ck_n_in(ck_n), .cke_in(cke), .cs_n_in(cs_n),
      .ras_n_in(pins[2]), .cas_n_in(pins[1]), .we_n_in(pins[0]), .array_group_sel_in(bank), .addr_in(addr),
      .dq_in(dq_bus), .dq_out(dq_dev), .dq_oe_out(dq_oe), .lower_data_strobe_in(lo_stb),
      .upper_data_strobe_in(hi_stb), .lower_data_strobe_out(lo_so), .upper_data_strobe_out(hi_so),
      .lower_data_strobe_oe_out(lo_soe), .upper_data_strobe_oe_out(hi_soe), .lower_byte_mask_in(lo_msk),
      .upper_byte_mask_in(hi_msk), .mode_reg_out(mode_reg), .bank_open_out(bank_open), .active_out(active));
   lpdpi_ctl_model u_ctl (.clk_in(clk_in), .dev_dq_in(dq_dev), .dev_dq_oe_in(dq_oe), .dev_lo_stb_in(lo_so),
      .dev_hi_stb_in(hi_so), .dev_lo_stb_oe_in(lo_soe), .dev_hi_stb_oe_in(hi_soe), .ck_out(ck), .ck_n_out(ck_n),
      .cke_out(cke), .cs_n_out(cs_n), .cmd_pins_out(pins), .bank_out(bank), .addr_out(addr), .dq_out(dq_bus),
      .lower_data_strobe_out(lo_stb), .upper_data_strobe_out(hi_stb), .lower_byte_mask_out(lo_msk),
      .upper_byte_mask_out(hi_msk));
   always #5 clk_in = ~clk_in;
   task check(input string what, input [15:0] exp, input [15:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp)
         begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   function [15:0] pat(input [2:0] c);
      pat = {1'b0, c, 1'b0, c, 1'b0, c, 1'b0, c};
   endfunction
   task t_reset;
      begin
         check("mode", 16'h0000, mode_reg);
         check("banks", 16'h0000, bank_open);
         check("drive", 16'h0000, dq_oe);
      end
   endtask
   task t_gate;
      begin
         u_ctl.cmd(`LPDPI_PIN_ACT, 2'h0, 13'h0005, 1'b1, 1'b0);
         check("desel act", 16'h0000, bank_open);
         u_ctl.cmd(`LPDPI_PIN_ACT, 2'h0, 13'h0005, 1'b0, 1'b1);
         check("bad cross", 16'h0000, bank_open);
         u_ctl.set_cke(1'b0);
         repeat (6) @(negedge clk_in);
         check("gated", 16'h0000, active);
         u_ctl.cmd(`LPDPI_PIN_ACT, 2'h0, 13'h0005, 1'b0, 1'b0);
         check("gated act", 16'h0000, bank_open);
         u_ctl.set_cke(1'b1);
         repeat (6) @(negedge clk_in);
         check("ungated", 16'h0001, active);
      end
   endtask
   task t_mode;
      begin
         u_ctl.cmd(`LPDPI_PIN_MRS, 2'h0, 13'h0003, 1'b0, 1'b0);
         check("opcode", 16'h0003, mode_reg);
         u_ctl.cmd(`LPDPI_PIN_MRS, 2'h0, 13'h0002, 1'b1, 1'b0);
         check("desel mode", 16'h0003, mode_reg);
      end
   endtask
   task t_banks;
      reg [3:0] e;
      integer   b;
      begin
         e = 4'h0;
         for (b = 0; b < 4; b = b + 1)
         begin
            u_ctl.cmd(`LPDPI_PIN_ACT, b[1:0], 13'h0100, 1'b0, 1'b0);
            e[b] = 1'b1;
            check("act", {12'h000, e}, bank_open);
         end
         for (b = 0; b < 3; b = b + 1)
         begin
            u_ctl.cmd(b == 0 ? `LPDPI_PIN_REF : (b == 1 ? 3'h7 : `LPDPI_PIN_BST), 2'h0, 13'h0000, 1'b0, 1'b0);
            check("idle", 16'h000F, bank_open);
         end
         u_ctl.cmd(`LPDPI_PIN_PRE, 2'h2, 13'h0000, 1'b0, 1'b0);
         check("pre one", 16'h000B, bank_open);
         u_ctl.cmd(`LPDPI_PIN_PRE, 2'h0, 13'h0400, 1'b0, 1'b0);
         check("pre all", 16'h0000, bank_open);
      end
   endtask
   task t_data;
      reg [15:0] w;
      reg [2:0]  c;
      integer    p, i;
      begin
         u_ctl.cmd(`LPDPI_PIN_ACT, 2'h1, 13'h0007, 1'b0, 1'b0);
         // Second pass masks odd beats low lane and beats 2,3,6,7 high lane
         for (p = 0; p < 2; p = p + 1)
         begin
            u_ctl.cmd(`LPDPI_PIN_WR, 2'h1, 13'h0000, 1'b0, 1'b0);
            for (i = 0; i < 8; i = i + 1)
            begin
               c = i[2:0];
               w = pat(c);
               u_ctl.wr_beat(p[0] ? ~w : w, p[0] & c[0], p[0] & c[1]);
               check("wr drive", 16'h0000, dq_oe);
            end
            u_ctl.wr_done;
         end
         u_ctl.cmd(`LPDPI_PIN_RD, 2'h1, 13'h0403, 1'b0, 1'b0);
         for (i = 0; i < 8; i = i + 1)
         begin
            c = i[2:0] + 3'h3;
            w = pat(c);
            u_ctl.ck_edge(6);
            check("word", {c[1] ? w[15:8] : ~w[15:8], c[0] ? w[7:0] : ~w[7:0]}, dq_dev);
            check("lo stb", {15'h0000, ~i[0]}, lo_so);
            check("hi stb", {15'h0000, ~i[0]}, hi_so);
            check("rd drive", 16'h0001, dq_oe);
            repeat (2) @(negedge clk_in);
         end
         u_ctl.ck_edge(6);
         check("end drive", 16'h0000, dq_oe);
         check("end stb drive", 16'h0000, {14'h0000, lo_soe, hi_soe});
         u_ctl.ck_edge(2);
         check("autoclose", 16'h0000, bank_open);
      end
   endtask
   always @(posedge clk_in)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end
   initial
   begin
      clk_in = 1'b0;
      rst_in = 1'b1;
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      repeat (10) @(negedge clk_in);
      rst_in = 1'b0;
      @(negedge clk_in);
      t_reset;
      t_gate;
      t_mode;
      t_banks;
      t_data;
      give_verdict;
   end
endmodule
bind lpdpi_core lpdpi_core_props u_props (.*);
